/* File: dv/bus_adapter_model.sv */
// adapter board model: ready stretching and cascade bus mastership
`timescale 1ns/10ps
`default_nettype none

module bus_adapter_model (
  input  wire logic       bus_clk,
  input  wire logic       refresh_seen,
  input  wire logic [7:0] dma_acknowledge_n,
  output logic            channel_ready,
  output logic [7:0]      dma_request_line,
  output logic            master_n
);
  initial begin
    channel_ready = 1'h1;
    dma_request_line = 8'h00;
    master_n = 1'h1;
  end

  // slow adapter: ready low until s bus clocks into the refresh
  task automatic arm_stall(input int s);
    channel_ready = 1'h0;
    @(negedge refresh_seen);
    repeat (s) @(posedge bus_clk);
    #1 channel_ready = 1'h1;
  endtask

  // take the bus through a cascade channel, keep it hold clocks
  task automatic own_bus(input int ch, input int hold);
    int n;
    n = 0;
    @(posedge bus_clk);
    #1 dma_request_line[ch] = 1'h1;
    while (dma_acknowledge_n[ch] !== 1'h0 && n < 300) begin
      @(posedge bus_clk);
      #1 n++;
    end
    master_n = 1'h0;
    repeat (hold) @(posedge bus_clk);
    #1 dma_request_line[ch] = 1'h0;
    master_n = 1'h1;
  endtask
endmodule

`default_nettype wire

/* File: dv/expansion_bus_refresh_mastership_tb.sv */
// self-checking bench for the expansion bus control block
`timescale 1ns/10ps
`default_nettype none

module expansion_bus_refresh_mastership_tb;
  import bus_ctl_pkg::*;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  logic sys_clk = 1'h0, bus_clk = 1'h0, reset_n = 1'h0, power_good = 1'h0;
  logic cpu_cycle_active = 1'h0, cpu_hold_ack = 1'h0, master_request_bit = 1'h0;
  logic [DMA_CH-1:0]       cascade_mode = 8'h00;
  logic [ADDR_W-1:0]       ext_master_addr = 24'h000000;
  logic [BASE_W-1:0]       window_base = 5'h00;
  logic [IRQ_BUS-1:0]      interrupt_request_line = 11'h000;
  logic [IRQ_INTERNAL-1:0] internal_irq = 4'h0;
  logic                    slave_int = 1'h0;
  logic bus_reset_out, cpu_hold_request, channel_ready, address_latch_strobe;
  logic address_enable_line, refresh_n, refresh_oe, system_address_oe;
  logic memory_read_strobe_n, low_meg_read_strobe_n, read_strobe_oe;
  logic ext_dma_request, master_n;
  logic [ROW_W-1:0]     system_address;
  logic [DMA_CH-1:0]    dma_request_line, dma_acknowledge_n;
  logic [ADDR_W-1:0]    translated_addr;
  logic [IRQ_TOTAL-1:0] pic_request;
  wire logic refresh_seen = refresh_oe ? refresh_n : 1'h1;
  int  n_fail = 0, num_checks = 0, n_ref = 0, cycles = 0;
  time t_start, t_up, t1;
  logic [3:0] drop [4] = '{4'hf, 4'hb, 4'h9, 4'h8};
  int  slot_of [16] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15, 0, 1, 8, 13, 2};

  initial forever #12.5 sys_clk = ~sys_clk;
  initial begin
    #3.7;
    forever #7.5 bus_clk = ~bus_clk;
  end

  bus_ctl dut (.sys_clk, .reset_n, .bus_clk, .power_good, .bus_reset_out,
    .cpu_cycle_active, .cpu_hold_request, .cpu_hold_ack, .channel_ready,
    .address_latch_strobe, .address_enable_line, .refresh_n, .refresh_oe,
    .system_address, .system_address_oe, .memory_read_strobe_n,
    .low_meg_read_strobe_n, .read_strobe_oe, .cascade_mode, .dma_request_line,
    .dma_acknowledge_n, .master_n, .master_request_bit, .ext_dma_request,
    .ext_master_addr, .window_base, .translated_addr, .interrupt_request_line,
    .internal_irq, .slave_int, .pic_request);

  bus_adapter_model adapter (.bus_clk, .refresh_seen, .dma_acknowledge_n,
    .channel_ready, .dma_request_line, .master_n);

  // --------------------------------------------------------------
  // compare, wait and closing tasks
  // --------------------------------------------------------------
  task automatic check_val(input logic [23:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, lo, hi, input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      conclude();
    end
  end

  always @(negedge refresh_n) n_ref++;

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic refresh_walk(input int stall);
    int n;
    n = 0;
    while (!(address_latch_strobe === 1'h1 && refresh_n === 1'h0) && n < 1500) begin
      @(posedge bus_clk);
      #1 n++;
    end
    t_start = $time;
    check_val({address_enable_line, refresh_oe, system_address_oe}, 3'h7, "start");
    check_val(system_address, 8'(n_ref - 1), "row");
    n = 0;
    @(posedge bus_clk);
    #1;
    while (memory_read_strobe_n === 1'h0 && n < 300) begin
      check_val({read_strobe_oe, low_meg_read_strobe_n}, 2'h2, "low strobe");
      @(posedge bus_clk);
      #1 n++;
    end
    if (stall == 0) check_cnt(n, 3, 3, "strobe clocks");
    else check_cnt(n, stall + 3, stall + 5, "stretched strobe");
    for (int i = 0; i < 4; i++) begin
      check_val({refresh_n, system_address_oe, address_latch_strobe,
        address_enable_line}, drop[i], "drop order");
      @(posedge bus_clk);
      #1;
    end
    check_val(refresh_oe, 1'h0, "refresh released");
  endtask

  task automatic cpu_scn();
    int k;
    cpu_cycle_active = 1'h1;
    k = n_ref;
    sys_wait(680);
    check_cnt(n_ref - k, 0, 0, "refresh in cpu cycle");
    cpu_cycle_active = 1'h0;
    refresh_walk(0);
  endtask

  task automatic master_scn();
    int n, k;
    n = 0;
    cascade_mode = 8'h20;
    fork
      adapter.own_bus(5, 1200);
    join_none
    while (cpu_hold_request !== 1'h1 && n < 50) begin
      sys_wait(1);
      n++;
    end
    check_val({cpu_hold_request, dma_acknowledge_n}, 9'h1ff, "hold before ack");
    k = n_ref;
    cpu_hold_ack = 1'h1;
    n = 0;
    while (master_n !== 1'h0 && n < 50) begin
      sys_wait(1);
      n++;
    end
    check_val(dma_acknowledge_n, 8'hdf, "cascade ack");
    n = 0;
    while (dma_request_line[5] === 1'h1 && n < 1000) begin
      check_val({address_enable_line, system_address_oe, read_strobe_oe,
        dma_acknowledge_n[5]}, 4'h0, "owned bus");
      sys_wait(1);
      n++;
    end
    check_cnt(n_ref - k, 0, 0, "refresh while owned");
    n = 0;
    while (dma_acknowledge_n !== 8'hff && n < 50) begin
      sys_wait(1);
      n++;
    end
    sys_wait(4);
    check_val({cpu_hold_request, dma_acknowledge_n}, 9'h0ff, "bus returned");
    check_cnt(n_ref - k, 1, 1, "deferred refresh");
    cpu_hold_ack = 1'h0;
    cascade_mode = 8'h00;
    refresh_walk(0);
  endtask

  task automatic misc_scn();
    master_request_bit = 1'h1;
    ext_master_addr = 24'habcdef;
    window_base = 5'h03;
    sys_wait(4);
    check_val(ext_dma_request, 1'h1, "ext request");
    check_val(translated_addr, 24'h1bcdef, "window");
    master_request_bit = 1'h0;
    sys_wait(4);
    check_val(ext_dma_request, 1'h0, "ext request off");
    for (int k = 0; k < 16; k++) begin
      {slave_int, internal_irq, interrupt_request_line} = 16'h0001 << k;
      sys_wait(4);
      check_val(pic_request, 16'h0001 << slot_of[k], "irq slot");
    end
    {slave_int, internal_irq, interrupt_request_line} = 16'h0000;
  endtask

  task automatic brownout_scn();
    power_good = 1'h0;
    sys_wait(3);
    check_val(bus_reset_out, 1'h1, "brownout reset");
    sys_wait(20);
    n_ref = 0;
    power_good = 1'h1;
    sys_wait(3);
    check_val(bus_reset_out, 1'h0, "power good again");
    t_up = $time;
    refresh_walk(0);
    check_cnt(int'(t_start - t_up), 14850, 15200, "restart interval");
  endtask

  initial begin
    sys_wait(12);
    check_val({bus_reset_out, dma_acknowledge_n, refresh_oe}, 10'h3fe, "in reset");
    reset_n = 1'h1;
    sys_wait(2);
    power_good = 1'h1;
    sys_wait(2);
    check_val(bus_reset_out, 1'h1, "reset held");
    sys_wait(1);
    check_val(bus_reset_out, 1'h0, "reset dropped");
    t_up = $time;
    refresh_walk(0);
    check_cnt(int'(t_start - t_up), 14850, 15200, "first interval");
    t1 = t_start;
    refresh_walk(0);
    check_cnt(int'(t_start - t1), 14850, 15150, "interval");
    fork
      adapter.arm_stall(6);
    join_none
    refresh_walk(6);
    cpu_scn();
    master_scn();
    misc_scn();
    brownout_scn();
    conclude();
  end
endmodule

`default_nettype wire

/* File: logic/bus_ctl.sv */
// expansion bus system-board control: refresh, mastership, interrupts, reset
//
// Operation
// - start refresh each 15 us interval
// - assert latch, enable, refresh together
// - advance refresh row after each cycle
// - drive row, assert both read strobes
// - low ready holds refresh cycle state
// - strobes negate two clocks after ready
// - then drop refresh, address, latch, enable
// - processor releases bus to acknowledged master
// - master asserted keeps enable line negated
// - cascade grant leaves bus lines undriven
// - master owns until request, master drop
// - request bit raises external dma request
// - external masters confined to 512 KB window
// - sixteen interrupt inputs, eleven on bus
// - bus reset is inverse of power good
// - bus reset at power-up and brownout
// - enable line degates ordinary io decode
`timescale 1ns/10ps
`default_nettype none

module bus_ctl
  import bus_ctl_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                bus_clk,
  input  wire logic                power_good,
  output logic                     bus_reset_out,
  input  wire logic                cpu_cycle_active,
  output logic                     cpu_hold_request,
  input  wire logic                cpu_hold_ack,
  input  wire logic                channel_ready,
  output logic                     address_latch_strobe,
  output logic                     address_enable_line,
  output logic                     refresh_n,
  output logic                     refresh_oe,
  output logic [ROW_W-1:0]         system_address,
  output logic                     system_address_oe,
  output logic                     memory_read_strobe_n,
  output logic                     low_meg_read_strobe_n,
  output logic                     read_strobe_oe,
  input  wire logic [DMA_CH-1:0]   cascade_mode,
  input  wire logic [DMA_CH-1:0]   dma_request_line,
  output logic [DMA_CH-1:0]        dma_acknowledge_n,
  input  wire logic                master_n,
  input  wire logic                master_request_bit,
  output logic                     ext_dma_request,
  input  wire logic [ADDR_W-1:0]   ext_master_addr,
  input  wire logic [BASE_W-1:0]   window_base,
  output logic [ADDR_W-1:0]        translated_addr,
  input  wire logic [IRQ_BUS-1:0]  interrupt_request_line,
  input  wire logic [IRQ_INTERNAL-1:0] internal_irq,
  input  wire logic                slave_int,
  output logic [IRQ_TOTAL-1:0]     pic_request
);

  // ------------------------------------------------------------------
  // system clock side: reset, refresh timebase, routing
  // ------------------------------------------------------------------
  logic [1:0]              pg_sync_reg;
  logic                    bus_reset_reg;
  logic [TIMER_W-1:0]      timer_reg;
  logic                    due_tgl_reg;
  logic [1:0]              hold_sync_reg;
  logic [1:0]              mreq_sync_reg;
  logic [IRQ_BUS-1:0]      irq_s1_reg;
  logic [IRQ_BUS-1:0]      irq_s2_reg;
  logic [IRQ_TOTAL-1:0]    pic_reg;
  logic [IRQ_TOTAL-1:0]    pic_next;
  logic [ADDR_W-1:0]       xlat_reg;
  logic                    hold_req_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_sync_reg   <= 2'b00;
      bus_reset_reg <= 1'b1;
    end else begin
      pg_sync_reg   <= {pg_sync_reg[0], power_good};
      bus_reset_reg <= ~pg_sync_reg[1];
    end
  end
  assign bus_reset_out = bus_reset_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_reg   <= TIMER_RESET;
      due_tgl_reg <= 1'b0;
    end else if (bus_reset_reg) begin
      timer_reg   <= TIMER_RESET;
    end else if (timer_reg == TIMER_LAST) begin
      timer_reg   <= TIMER_RESET;
      due_tgl_reg <= ~due_tgl_reg;
    end else begin
      timer_reg   <= timer_reg + 10'h001;
    end
  end

  // hold request from the bus side, and the alternate request bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_sync_reg <= 2'b00;
      mreq_sync_reg <= 2'b00;
    end else begin
      hold_sync_reg <= {hold_sync_reg[0], hold_req_reg};
      mreq_sync_reg <= {mreq_sync_reg[0], master_request_bit};
    end
  end
  assign cpu_hold_request = hold_sync_reg[1];
  assign ext_dma_request  = mreq_sync_reg[1];

  // external master addresses folded into one contiguous window
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xlat_reg <= ADDR_RESET;
    end else begin
      xlat_reg <= {window_base, ext_master_addr[WINDOW_BITS-1:0]};
    end
  end
  assign translated_addr = xlat_reg;

  always_comb begin
    int b;
    int n;
    b = 0;
    n = 0;
    pic_next = IRQ_RESET;
    for (int i = 0; i < IRQ_TOTAL; i++) begin
      if (i == CASCADE_SLOT) begin
        pic_next[i] = slave_int;
      end else if (INTERNAL_MASK[i]) begin
        pic_next[i] = internal_irq[n];
        n = n + 1;
      end else begin
        pic_next[i] = irq_s2_reg[b];
        b = b + 1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
      pic_reg    <= IRQ_RESET;
    end else begin
      irq_s1_reg <= interrupt_request_line;
      irq_s2_reg <= irq_s1_reg;
      pic_reg    <= pic_next;
    end
  end
  assign pic_request = pic_reg;

  // ------------------------------------------------------------------
  // bus clock side: synchronisers
  // ------------------------------------------------------------------
  logic [2:0]          due_sync_reg;
  logic [1:0]          rst_sync_reg;
  logic [1:0]          busy_sync_reg;
  logic [1:0]          ack_sync_reg;
  logic [1:0]          rdy_sync_reg;
  logic [1:0]          mst_sync_reg;
  logic [DMA_CH-1:0]   drq_s1_reg;
  logic [DMA_CH-1:0]   drq_s2_reg;
  logic [DMA_CH-1:0]   casc_s1_reg;
  logic [DMA_CH-1:0]   casc_s2_reg;

  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      due_sync_reg  <= 3'b000;
      rst_sync_reg  <= 2'b11;
      busy_sync_reg <= 2'b00;
      ack_sync_reg  <= 2'b00;
      rdy_sync_reg  <= 2'b11;
      mst_sync_reg  <= 2'b11;
      drq_s1_reg    <= '0;
      drq_s2_reg    <= '0;
      casc_s1_reg   <= '0;
      casc_s2_reg   <= '0;
    end else begin
      due_sync_reg  <= {due_sync_reg[1:0], due_tgl_reg};
      rst_sync_reg  <= {rst_sync_reg[0], bus_reset_reg};
      busy_sync_reg <= {busy_sync_reg[0], cpu_cycle_active};
      ack_sync_reg  <= {ack_sync_reg[0], cpu_hold_ack};
      rdy_sync_reg  <= {rdy_sync_reg[0], channel_ready};
      mst_sync_reg  <= {mst_sync_reg[0], master_n};
      drq_s1_reg    <= dma_request_line;
      drq_s2_reg    <= drq_s1_reg;
      casc_s1_reg   <= cascade_mode;
      casc_s2_reg   <= casc_s1_reg;
    end
  end

  logic due_pulse;
  logic ready_high;
  logic master_low;
  logic bus_in_reset;
  assign due_pulse    = due_sync_reg[2] ^ due_sync_reg[1];
  assign ready_high   = rdy_sync_reg[1];
  assign master_low   = ~mst_sync_reg[1];
  assign bus_in_reset = rst_sync_reg[1];

  // ------------------------------------------------------------------
  // refresh sequencer
  // ------------------------------------------------------------------
  refresh_state_t      rstate_reg;
  arb_state_t          astate_reg;
  logic                pending_reg;
  logic [ROW_W-1:0]    row_reg;
  logic                refresh_go;

  assign refresh_go = pending_reg && !busy_sync_reg[1] && (astate_reg == A_IDLE)
                      && (rstate_reg == R_IDLE) && !bus_in_reset;

  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg <= 1'b0;
    end else if (due_pulse) begin
      pending_reg <= 1'b1;
    end else if (refresh_go) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstate_reg <= R_IDLE;
    end else begin
      case (rstate_reg)
        R_IDLE:      if (refresh_go) rstate_reg <= R_START;
        R_START:     rstate_reg <= R_STROBE;
        R_STROBE:    if (ready_high) rstate_reg <= R_WAIT1;
        R_WAIT1:     rstate_reg <= R_WAIT2;
        R_WAIT2:     rstate_reg <= R_DROP_REF;
        R_DROP_REF:  rstate_reg <= R_DROP_ADDR;
        R_DROP_ADDR: rstate_reg <= R_DROP_ALE;
        R_DROP_ALE:  rstate_reg <= R_DROP_EN;
        R_DROP_EN:   rstate_reg <= R_IDLE;
        default:     rstate_reg <= R_IDLE;
      endcase
    end
  end

  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      row_reg <= ROW_RESET;
    end else if (bus_in_reset) begin
      row_reg <= ROW_RESET;
    end else if (rstate_reg == R_DROP_EN) begin
      row_reg <= row_reg + ROW_STEP;
    end
  end

  // line levels decoded from the sequencer state
  logic in_refresh;
  logic strobes_on;
  assign in_refresh = (rstate_reg != R_IDLE);
  assign strobes_on = (rstate_reg == R_STROBE) || (rstate_reg == R_WAIT1)
                      || (rstate_reg == R_WAIT2);

  // each drop state is the first cycle in which its line is negated
  assign address_latch_strobe  = in_refresh && (rstate_reg < R_DROP_ALE);
  assign address_enable_line   = in_refresh && (rstate_reg < R_DROP_EN)
                                 && !master_low;
  assign refresh_n             = !(in_refresh && (rstate_reg < R_DROP_REF));
  assign refresh_oe            = in_refresh;
  assign system_address        = row_reg;
  assign system_address_oe     = in_refresh && (rstate_reg < R_DROP_ADDR);
  assign memory_read_strobe_n  = !strobes_on;
  assign low_meg_read_strobe_n = !strobes_on;
  assign read_strobe_oe        = in_refresh && (rstate_reg < R_DROP_REF);

  // ------------------------------------------------------------------
  // cascade-channel mastership
  // ------------------------------------------------------------------
  logic [DMA_CH-1:0] casc_req;
  logic [DMA_CH-1:0] grant_reg;
  assign casc_req = drq_s2_reg & casc_s2_reg;

  always_ff @(posedge bus_clk or negedge reset_n) begin
    if (!reset_n) begin
      astate_reg   <= A_IDLE;
      grant_reg    <= '0;
      hold_req_reg <= 1'b0;
    end else begin
      case (astate_reg)
        A_IDLE: if (|casc_req && !pending_reg && rstate_reg == R_IDLE) begin
          grant_reg    <= lowest_set(casc_req);
          hold_req_reg <= 1'b1;
          astate_reg   <= A_HOLD;
        end
        A_HOLD: if (ack_sync_reg[1]) begin
          astate_reg <= A_GRANT;
        end
        A_GRANT: if (master_low) begin
          astate_reg <= A_OWNED;
        end else if (!(|(casc_req & grant_reg))) begin
          astate_reg   <= A_IDLE;
          hold_req_reg <= 1'b0;
        end
        A_OWNED: if (!master_low && !(|(drq_s2_reg & grant_reg))) begin
          astate_reg   <= A_IDLE;
          hold_req_reg <= 1'b0;
        end
        default: astate_reg <= A_IDLE;
      endcase
    end
  end
  assign dma_acknowledge_n = ((astate_reg == A_GRANT) || (astate_reg == A_OWNED))
                             ? ~grant_reg : DACK_IDLE;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence strobes_held_two;
    !memory_read_strobe_n ##1 !memory_read_strobe_n ##1 memory_read_strobe_n;
  endsequence

  sequence drop_in_order;
    refresh_n && system_address_oe ##1 !system_address_oe && address_latch_strobe
    ##1 !address_latch_strobe && address_enable_line ##1 !address_enable_line;
  endsequence

  refresh_open_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    $rose(in_refresh) |-> address_latch_strobe && !refresh_n
                          && (address_enable_line || master_low))
    else $error("refresh start lines not asserted together");

  strobe_neg_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (rstate_reg == R_STROBE) && ready_high |=> strobes_held_two)
    else $error("read strobes not dropped two clocks after ready");

  ready_stall_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (rstate_reg == R_STROBE) && !ready_high |=> !memory_read_strobe_n
                                                && (rstate_reg == R_STROBE))
    else $error("refresh advanced while ready low");

  end_order_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (rstate_reg == R_WAIT2) |=> drop_in_order)
    else $error("refresh end order wrong");

  row_step_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (rstate_reg == R_DROP_EN) && !bus_in_reset |=> row_reg == $past(row_reg) + ROW_STEP)
    else $error("refresh row not advanced");

  enable_master_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    master_low |-> !address_enable_line)
    else $error("enable line asserted under master");

  cascade_float_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (astate_reg != A_IDLE) |-> !system_address_oe && !read_strobe_oe)
    else $error("bus lines driven during cascade grant");

  keep_owner_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (astate_reg == A_OWNED) && (master_low || |(drq_s2_reg & grant_reg))
    |=> (astate_reg == A_OWNED) && (dma_acknowledge_n == $past(dma_acknowledge_n)))
    else $error("bus reclaimed from master too early");

  wait_idle_a: assert property (@(posedge bus_clk) disable iff (!reset_n)
    (rstate_reg == R_IDLE) && busy_sync_reg[1] |=> (rstate_reg == R_IDLE))
    else $error("refresh started during a bus cycle");

  reset_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 bus_reset_out == !$past(pg_sync_reg[1]))
    else $error("bus reset not inverse of power good");

  timer_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    bus_reset_reg |=> timer_reg == TIMER_RESET)
    else $error("refresh timer running during bus reset");

  interval_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !bus_reset_reg && (timer_reg == TIMER_LAST) |=> due_tgl_reg != $past(due_tgl_reg))
    else $error("refresh interval expiry missed");

endmodule

`default_nettype wire

/* File: logic/bus_ctl_pkg.sv */
// constants, types and helpers shared by the expansion bus control logic
package bus_ctl_pkg;

  // --------------------------------------------------------------------
  // refresh timebase
  // --------------------------------------------------------------------
  localparam int REFRESH_INTERVAL_NS = 15000;
  localparam int SYS_CLK_PERIOD_NS   = 25;
  localparam int REFRESH_CYCLES      = REFRESH_INTERVAL_NS / SYS_CLK_PERIOD_NS;
  localparam int TIMER_W             = 10;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 10'h000;
  localparam logic [TIMER_W-1:0] TIMER_LAST  = TIMER_W'(REFRESH_CYCLES - 1);

  // --------------------------------------------------------------------
  // refresh row, dma channels, address window
  // --------------------------------------------------------------------
  localparam int              ROW_W       = 8;
  localparam logic [ROW_W-1:0] ROW_RESET  = 8'h00;
  localparam logic [ROW_W-1:0] ROW_STEP   = 8'h01;
  localparam int              DMA_CH      = 8;
  localparam logic [DMA_CH-1:0] DACK_IDLE = 8'hff;
  localparam int              ADDR_W      = 24;
  localparam int              WINDOW_BITS = 19;
  localparam int              BASE_W      = ADDR_W - WINDOW_BITS;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;

  // --------------------------------------------------------------------
  // interrupt routing
  // --------------------------------------------------------------------
  localparam int              IRQ_TOTAL     = 16;
  localparam int              IRQ_BUS       = 11;
  localparam int              IRQ_INTERNAL  = 4;
  localparam int              CASCADE_SLOT  = 2;
  localparam logic [15:0]     INTERNAL_MASK = 16'h2103;
  localparam logic [15:0]     IRQ_RESET     = 16'h0000;

  typedef enum logic [3:0] {
    R_IDLE, R_START, R_STROBE, R_WAIT1, R_WAIT2,
    R_DROP_REF, R_DROP_ADDR, R_DROP_ALE, R_DROP_EN
  } refresh_state_t;

  typedef enum logic [1:0] {
    A_IDLE, A_HOLD, A_GRANT, A_OWNED
  } arb_state_t;

  // one-hot of the lowest set bit
  function automatic logic [DMA_CH-1:0] lowest_set(input logic [DMA_CH-1:0] v);
    logic [DMA_CH-1:0] r;
    r = v & (~v + 8'h01);
    return r;
  endfunction

endpackage
